/* File: hw/cmp_consts.vh */
// constants for the dual comparator control block
//
// Functional notes
// - three-bit mode field picks one of eight pin and comparator setups.
// - pins in analog use read back zero from the port.
// - analog pins lose input buffer; output pins take comparator result.
// - both comparator results are always readable in the control register.
// - mode 110 drives both results onto their output pins.
// - result is one when plus input is higher, XOR invert bit.
// - switch bit picks inverting input in mode 001 (first) and 010 (both).
// - in switch modes both candidate pins stay analog.
// - flag sets on output change, seen as mismatch of two latches.
// - read latch captures output on each control register read.
// - sample latch captures output on every first clock phase.
// - mismatch holds flag true until read or output returns.
// - a control register write also refreshes the read latch.
// - software clears flag by writing zero; writing one sets it.
// - interrupt request needs comparator, peripheral and global enables.
// - clearing the flag has no effect while mismatch persists.
// - change exactly at a read may fail to set the flag.
// - comparators run in sleep; modes 000 and 111 turn them off.
// - change wakes device with comparator and peripheral enables set.
// - reset puts mode at 000, pins analog, comparators off.
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

// control register layout
`define CTRL_WIDTH        8
`define CTRL_MODE_MSB     2
`define CTRL_MODE_LSB     0
`define CTRL_SWITCH_BIT   3
`define CTRL_INV1_BIT     4
`define CTRL_INV2_BIT     5
`define CTRL_OUT1_BIT     6
`define CTRL_OUT2_BIT     7
`define CTRL_RESET        6'h00

// mode encodings
`define MODE_RESET        3'h0
`define MODE_SWITCH_ONE   3'h1
`define MODE_SWITCH_BOTH  3'h2
`define MODE_COMMON_REF   3'h3
`define MODE_INDEPENDENT  3'h4
`define MODE_SINGLE       3'h5
`define MODE_OUTPUTS      3'h6
`define MODE_OFF          3'h7

// comparator pin indices
`define PIN_COUNT         6
`define PIN_C1_NEG        0
`define PIN_C1_POS        1
`define PIN_C2_NEG        2
`define PIN_C2_POS        3
`define PIN_C1_OUT        4
`define PIN_C2_OUT        5

// bias settling time and clock rate
`define BIAS_SETTLE_NS    1000
`define CLOCK_PERIOD_NS   40
`define BIAS_SETTLE_CYCLES \
	((`BIAS_SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

/* File: hw/pin_mode_decode.v */
// decode of the mode field into pin roles and comparator enables
`timescale 1ns/1ps
`include "cmp_consts.vh"

module pin_mode_decode
(
	input  wire [2:0] mode,          // mode select field
	input  wire       switchBit,     // input switch bit
	output wire [5:0] analogMask,    // one per pin in analog use
	output wire [5:0] digitalMask,   // one per pin driven by a comparator
	output wire [1:0] compOn,        // comparator powered
	output wire [1:0] invInputSelect // alternate inverting input chosen
);

	// pin role table for the analog decode; power decode has its own table
	function [5:0] analog_pins;
		input [2:0] m;
		begin
			case (m)
				`MODE_RESET:       analog_pins = 6'h0F;
				`MODE_SWITCH_ONE:  analog_pins = 6'h0F;
				`MODE_SWITCH_BOTH: analog_pins = 6'h0F;
				`MODE_COMMON_REF:  analog_pins = 6'h0D;
				`MODE_INDEPENDENT: analog_pins = 6'h0F;
				`MODE_SINGLE:      analog_pins = 6'h0C;
				`MODE_OUTPUTS:     analog_pins = 6'h0F;
				`MODE_OFF:         analog_pins = 6'h00;
				default:           analog_pins = 6'h0F;
			endcase
		end
	endfunction

	// power decode; off modes keep the analog cores unbiased
	function [1:0] powered;
		input [2:0] m;
		begin
			case (m)
				`MODE_RESET: powered = 2'h0;
				`MODE_OFF:   powered = 2'h0;
				`MODE_SINGLE: powered = 2'h2;
				default:     powered = 2'h3;
			endcase
		end
	endfunction

	assign analogMask  = analog_pins(mode);
	assign digitalMask = (mode == `MODE_OUTPUTS) ? 6'h30 : 6'h00;
	assign compOn      = powered(mode);

	// switch reaches the first comparator in 001, both in 010
	assign invInputSelect[0] = switchBit &
		((mode == `MODE_SWITCH_ONE) || (mode == `MODE_SWITCH_BOTH));
	assign invInputSelect[1] = switchBit & (mode == `MODE_SWITCH_BOTH);

endmodule // pin_mode_decode

/* File: hw/cmp_mismatch.v */
// two-latch mismatch detector for one comparator output
`timescale 1ns/1ps

module cmp_mismatch
(
	input  wire clock,        // system clock
	input  wire rst,          // synchronous reset, active high
	input  wire clockEnable,  // freezes state while low
	input  wire outValue,     // current comparator result
	input  wire captureRead,  // control register read or write
	output wire mismatch      // latches disagree
);

	reg readLatch_reg;   // value seen at last register access
	reg sampleLatch_reg; // value seen at last first clock phase

	// every enabled edge stands for a first clock phase
	always @(posedge clock)
	begin
		if (rst)
		begin
			readLatch_reg   <= 1'b0;
			sampleLatch_reg <= 1'b0;
		end
		else if (clockEnable)
		begin
			sampleLatch_reg <= outValue;
			if (captureRead)
				readLatch_reg <= outValue;
		end
	end

	// a change caught by both latches on a read edge is lost
	assign mismatch = readLatch_reg ^ sampleLatch_reg;

endmodule // cmp_mismatch

/* File: hw/dual_comparator_control.v */
// digital control around a pair of analog comparators
`timescale 1ns/1ps
`include "cmp_consts.vh"

module dual_comparator_control
#(
	parameter PIN_COUNT    = `PIN_COUNT,          // comparator pins
	parameter SETTLE_COUNT = `BIAS_SETTLE_CYCLES  // bias settling cycles
)
(
	input  wire                 clock,             // system clock
	input  wire                 rst,               // sync reset
	input  wire                 clockEnable,       // freezes all state
	input  wire                 ctrlWrite,         // control write strobe
	input  wire                 ctrlRead,          // control read strobe
	input  wire [7:0]           ctrlWriteData,     // control write value
	output reg  [7:0]           ctrlReadData,      // control read value
	output reg  [5:0]           ctrlValue,         // stored settings
	input  wire                 flagWrite,         // flag write strobe
	input  wire [1:0]           flagWriteData,     // flag write value
	output reg  [1:0]           irqFlag,           // change flags
	input  wire [1:0]           cmpIrqEnable,      // per comparator enable
	input  wire                 periphIrqEnable,   // peripheral enable
	input  wire                 globalIrqEnable,   // global enable
	output reg                  irqRequest,        // interrupt request
	output reg                  wakeRequest,       // wake from sleep
	input  wire [1:0]           rawCompare,        // plus above minus
	output reg  [1:0]           compEnable,        // comparator power
	output reg  [1:0]           invInputSelect,    // alternate minus input
	output reg  [1:0]           compResult,        // registered results
	output reg                  biasSettled,       // settling time passed
	input  wire [PIN_COUNT-1:0] pinLevel,          // pad input levels
	input  wire [PIN_COUNT-1:0] portLatch,         // port output latch
	input  wire [PIN_COUNT-1:0] pinDirection,      // one means input
	output reg  [PIN_COUNT-1:0] portReadValue,     // port read value
	output reg  [PIN_COUNT-1:0] pinOut,            // pad output value
	output reg  [PIN_COUNT-1:0] pinOutEnable,      // pad driver on
	output reg  [PIN_COUNT-1:0] inputBufferEnable  // pad input buffer on
);

	// last count value, cut to the counter width on purpose
	localparam integer SETTLE_LAST_INT = SETTLE_COUNT - 1;
	localparam [7:0]   SETTLE_LAST     = SETTLE_LAST_INT[7:0];

	// stored control settings
	reg  [5:0] ctrl_reg;
	wire [2:0] mode      = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	wire       switchBit = ctrl_reg[`CTRL_SWITCH_BIT];
	wire [1:0] invBits   = {ctrl_reg[`CTRL_INV2_BIT],
		ctrl_reg[`CTRL_INV1_BIT]};

	// mode decode results
	wire [5:0] analogMask;
	wire [5:0] digitalMask;
	wire [1:0] compOn;
	wire [1:0] switchSel;

	// comparator results and mismatch state
	wire [1:0] result;
	wire [1:0] mismatch;
	wire       access = ctrlRead | ctrlWrite;

	// flag next values
	reg  [1:0] irqFlag_next;

	// bias settling state
	reg  [1:0] compOnPrev_reg;
	reg  [7:0] settleCount_reg;
	reg  [7:0] settleCount_next;
	reg        settled_next;

	// mode decode
	pin_mode_decode u_decode
	(
		.mode           (mode),
		.switchBit      (switchBit),
		.analogMask     (analogMask),
		.digitalMask    (digitalMask),
		.compOn         (compOn),
		.invInputSelect (switchSel)
	);

	// powered-off comparators contribute a zero before the invert
	assign result = (rawCompare & compOn) ^ invBits;

	// one mismatch detector per comparator
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_cmp
			cmp_mismatch u_mismatch
			(
				.clock       (clock),
				.rst         (rst),
				.clockEnable (clockEnable),
				.outValue    (result[c]),
				.captureRead (access),
				.mismatch    (mismatch[c])
			);
		end
	endgenerate

	// control register; writes touch only the writable low six bits
	always @(posedge clock)
	begin
		if (rst)
			ctrl_reg <= `CTRL_RESET;
		else if (clockEnable && ctrlWrite)
			ctrl_reg <= ctrlWriteData[5:0];
	end

	// read data updates on reads only, result bits live
	always @(posedge clock)
	begin
		if (rst)
			ctrlReadData <= 8'h00;
		else if (clockEnable && ctrlRead)
			ctrlReadData <= {result, ctrl_reg};
	end

	// flag next value: hardware set beats a software clear
	always @*
	begin
		irqFlag_next = irqFlag;
		if (flagWrite)
			irqFlag_next = flagWriteData;
		irqFlag_next = irqFlag_next | mismatch;
	end

	// flags and requests; requests lag the flag by one cycle
	always @(posedge clock)
	begin
		if (rst)
		begin
			irqFlag     <= 2'h0;
			irqRequest  <= 1'b0;
			wakeRequest <= 1'b0;
		end
		else if (clockEnable)
		begin
			irqFlag     <= irqFlag_next;
			irqRequest  <= (|(irqFlag & cmpIrqEnable)) &
				periphIrqEnable & globalIrqEnable;
			wakeRequest <= (|(irqFlag & cmpIrqEnable)) &
				periphIrqEnable;
		end
	end

	// analog side controls and visible results
	always @(posedge clock)
	begin
		if (rst)
		begin
			compEnable     <= 2'h0;
			invInputSelect <= 2'h0;
			compResult     <= 2'h0;
			ctrlValue      <= `CTRL_RESET;
		end
		else if (clockEnable)
		begin
			compEnable     <= compOn;
			invInputSelect <= switchSel;
			compResult     <= result;
			ctrlValue      <= ctrl_reg;
		end
	end

	// pin roles; a comparator pin maps to its own result
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p = p + 1)
		begin : g_pin
			wire pinResult = (p == `PIN_C2_OUT) ? result[1] : result[0];
			always @(posedge clock)
			begin
				if (rst)
				begin
					portReadValue[p]     <= 1'b0;
					pinOut[p]            <= 1'b0;
					pinOutEnable[p]      <= 1'b0;
					inputBufferEnable[p] <= 1'b0;
				end
				else if (clockEnable)
				begin
					// analog pins read zero whatever the pad does
					portReadValue[p] <= pinLevel[p] &
						~analogMask[p];
					inputBufferEnable[p] <= ~analogMask[p];
					pinOut[p] <= digitalMask[p] ?
						pinResult : portLatch[p];
					// driver follows direction; software clears it
					pinOutEnable[p] <= ~pinDirection[p];
				end
			end
		end
	endgenerate

	// settling counter restarts when any comparator is newly powered
	always @*
	begin
		settleCount_next = settleCount_reg;
		settled_next     = biasSettled;
		if (compOn == 2'h0)
		begin
			settleCount_next = 8'h00;
			settled_next     = 1'b0;
		end
		else if ((compOn & ~compOnPrev_reg) != 2'h0)
		begin
			settleCount_next = 8'h00;
			settled_next     = 1'b0;
		end
		else if (!biasSettled)
		begin
			if (settleCount_reg == SETTLE_LAST)
				settled_next = 1'b1;
			else
				settleCount_next = settleCount_reg + 8'h01;
		end
	end

	// settling status only informs software; flags are not masked
	always @(posedge clock)
	begin
		if (rst)
		begin
			compOnPrev_reg  <= 2'h0;
			settleCount_reg <= 8'h00;
			biasSettled     <= 1'b0;
		end
		else if (clockEnable)
		begin
			compOnPrev_reg  <= compOn;
			settleCount_reg <= settleCount_next;
			biasSettled     <= settled_next;
		end
	end

endmodule // dual_comparator_control

/* File: sim/cmp_core_model.sv */
// behavioural model of the analog comparator cores and the pads
`timescale 1ns/1ps
module cmp_core_model
(
	input  wire       clock,        // system clock
	input  wire [1:0] compEnable,   // core power
	input  wire [1:0] plusAbove,    // commanded input relation
	input  wire [5:0] pinOut,       // pad output value
	input  wire [5:0] pinOutEnable, // pad driver on
	input  wire [5:0] extLevel,     // level applied from outside
	output wire [1:0] rawCompare,   // plus above minus
	output wire [5:0] pinLevel      // resolved pad level
);
	reg [1:0] noise_reg = 2'h0;

	// an unpowered core has no valid answer, so its output wanders
	always @(posedge clock)
		noise_reg <= ~noise_reg;
	assign rawCompare = (compEnable & plusAbove) |
		(~compEnable & noise_reg);
	// a driven pad shows its driver, otherwise the outside level
	assign pinLevel = (pinOutEnable & pinOut) | (~pinOutEnable & extLevel);
endmodule // cmp_core_model

/* File: sim/dual_comparator_control_properties.sv */
// concurrent checks on the dual comparator control ports
`timescale 1ns/1ps
module dual_comparator_control_properties
#(
	parameter PIN_COUNT = 6 // comparator pins
)
(
	input wire                 clock,            // clock
	input wire                 rst,              // reset
	input wire                 clockEnable,      // run
	input wire                 ctrlWrite,        // write
	input wire                 ctrlRead,         // read
	input wire                 flagWrite,        // flag write
	input wire [1:0]           flagWriteData,    // flag value
	input wire [1:0]           cmpIrqEnable,     // enables
	input wire                 periphIrqEnable,  // enable
	input wire                 globalIrqEnable,  // enable
	input wire [7:0]           ctrlReadData,     // read value
	input wire [5:0]           ctrlValue,        // settings
	input wire [1:0]           irqFlag,          // flags
	input wire                 irqRequest,       // request
	input wire                 wakeRequest,      // wake
	input wire [1:0]           compResult,       // results
	input wire [1:0]           invInputSelect,   // minus select
	input wire [PIN_COUNT-1:0] portReadValue,    // port read
	input wire [PIN_COUNT-1:0] inputBufferEnable // buffers
);
	reg [1:0] quiet_reg;

	// edges since the last control access; a change near one may go unseen
	always @(posedge clock)
		quiet_reg <= (rst || ctrlRead || ctrlWrite) ? 2'h0 :
			quiet_reg + {1'h0, quiet_reg != 2'h3};

	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	// steps of a flagged change and of a read
	sequence quiet_change;
		$changed(compResult[0]) && quiet_reg == 2'h3 && clockEnable;
	endsequence
	sequence read_edge;
		ctrlRead && clockEnable;
	endsequence

	irq_gate_a: assert property (clockEnable |=> irqRequest ==
		$past(|(irqFlag & cmpIrqEnable) & periphIrqEnable & globalIrqEnable))
		else $error("interrupt request does not follow enables");
	wake_gate_a: assert property (clockEnable |=> wakeRequest ==
		$past(|(irqFlag & cmpIrqEnable) & periphIrqEnable))
		else $error("wake request does not follow enables");
	reset_state_a: assert property (disable iff (1'h0) rst |=>
		irqFlag == 2'h0 && ctrlValue == 6'h00)
		else $error("reset left state behind");
	// modes 000 and 001 must keep all four input pins analog
	analog_zero_a: assert property (
		(portReadValue & ~inputBufferEnable) == '0 &&
		(ctrlValue[2:1] != 2'h0 || inputBufferEnable[3:0] == 4'h0))
		else $error("analog pin reads nonzero");
	freeze_hold_a: assert property (!clockEnable |=>
		$stable(irqFlag) && $stable(ctrlReadData))
		else $error("state moved while frozen");
	switch_pair_a: assert property (
		invInputSelect[1] |-> invInputSelect[0])
		else $error("second switch without first");
	read_capture_a: assert property (
		read_edge ##1 $stable(compResult) |-> ctrlReadData[7:6] == compResult)
		else $error("read value lacks results");
	flag_clear_a: assert property ($fell(irqFlag[0]) |->
		$past(flagWrite && clockEnable && !flagWriteData[0]))
		else $error("flag fell without a clear");
	change_flag_a: assert property (
		quiet_change |-> ##[0:2] irqFlag[0])
		else $error("output change not flagged");
endmodule // dual_comparator_control_properties

/* File: sim/dual_comparator_control_tb.sv */
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_tb;
	logic       clock = 1'h0;
	logic       rst = 1'h1;
	logic       clockEnable = 1'h1;
	logic       ctrlWrite = 1'h0;
	logic       ctrlRead = 1'h0;
	logic       flagWrite = 1'h0;
	logic [7:0] ctrlWriteData = 8'h00;
	logic [1:0] flagWriteData = 2'h0;
	logic [1:0] cmpIrqEnable = 2'h0;
	logic       periphIrqEnable = 1'h0;
	logic       globalIrqEnable = 1'h0;
	logic [1:0] plusAbove = 2'h3;
	wire  [7:0] ctrlReadData;
	wire  [5:0] ctrlValue, pinLevel, portReadValue, pinOut, pinOutEnable;
	wire  [5:0] inputBufferEnable;
	wire  [1:0] irqFlag, rawCompare, compEnable, invInputSelect, compResult;
	wire        irqRequest, wakeRequest, biasSettled;
	int         n_mismatch = 0;
	int         n_compared = 0;
	// analog pins 0-3 and comparator power, one entry per mode
	localparam [31:0] AM = 32'h0FCFDFFF;
	localparam [15:0] CE = 16'h3BFC;

	dual_comparator_control #(.SETTLE_COUNT(3)) DUT (
		.clock(clock), .rst(rst), .clockEnable(clockEnable),
		.ctrlWrite(ctrlWrite), .ctrlRead(ctrlRead),
		.ctrlWriteData(ctrlWriteData), .ctrlReadData(ctrlReadData),
		.ctrlValue(ctrlValue), .flagWrite(flagWrite),
		.flagWriteData(flagWriteData), .irqFlag(irqFlag),
		.cmpIrqEnable(cmpIrqEnable), .periphIrqEnable(periphIrqEnable),
		.globalIrqEnable(globalIrqEnable), .irqRequest(irqRequest),
		.wakeRequest(wakeRequest), .rawCompare(rawCompare),
		.compEnable(compEnable), .invInputSelect(invInputSelect),
		.compResult(compResult), .biasSettled(biasSettled),
		.pinLevel(pinLevel), .portLatch(6'h00), .pinDirection(6'h0F),
		.portReadValue(portReadValue), .pinOut(pinOut),
		.pinOutEnable(pinOutEnable), .inputBufferEnable(inputBufferEnable));
	cmp_core_model core (.clock(clock), .compEnable(compEnable),
		.plusAbove(plusAbove), .pinOut(pinOut), .pinOutEnable(pinOutEnable),
		.extLevel(6'h3F), .rawCompare(rawCompare), .pinLevel(pinLevel));

	always #20 clock = ~clock;

	task automatic end_sim;
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic cmp(input string nm, input [7:0] e, input [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle strobe: 0 control write, 1 control read, 2 flag write
	task automatic pulse(input int k, input [7:0] d);
		@(posedge clock);
		ctrlWrite <= (k == 0);
		ctrlRead <= (k == 1);
		flagWrite <= (k == 2);
		ctrlWriteData <= d;
		flagWriteData <= d[1:0];
		@(posedge clock);
		{ctrlWrite, ctrlRead, flagWrite} <= 3'h0;
	endtask
	task automatic t_reset;
		tick(1);
		cmp("ctrlValue", 8'h00, ctrlValue);
		cmp("compEnable", 8'h00, compEnable);
		cmp("bufferEn", 8'h00, inputBufferEnable[3:0]);
		cmp("outEnable", 8'h30, pinOutEnable);
	endtask
	// reset in mid-run clears settings and flags
	task automatic t_midreset;
		pulse(2, 8'h03);
		@(posedge clock) rst <= 1'h1;
		tick(2);
		cmp("ctrlValue", 8'h00, ctrlValue);
		cmp("flagReset", 8'h00, irqFlag);
		@(posedge clock) rst <= 1'h0;
		tick(2);
		cmp("compEnable", 8'h00, compEnable);
	endtask
	// interrupts stay disabled while the mode moves
	task automatic t_modes;
		for (int m = 0; m < 8; m++)
		begin
			pulse(0, m[7:0]);
			tick(4);
			cmp("compEnable", CE[m*2+:2], compEnable);
			cmp("settled", {7'h00, |CE[m*2+:2]}, biasSettled);
			cmp("portRead", {4'h0, ~AM[m*4+:4]}, portReadValue[3:0]);
			cmp("bufferEn", {4'h0, ~AM[m*4+:4]}, inputBufferEnable[3:0]);
			cmp("pinOut", (m == 6) ? 8'h03 : 8'h00, pinOut[5:4]);
		end
	endtask
	task automatic t_invert;
		for (int v = 0; v < 16; v++)
		begin
			@(posedge clock) plusAbove <= v[1:0];
			pulse(0, {2'h0, v[3:2], 4'h4});
			tick(3);
			pulse(1, 8'h00);
			tick(1);
			cmp("result", v[1:0] ^ v[3:2], ctrlReadData[7:6]);
			cmp("compResult", v[1:0] ^ v[3:2], compResult);
			cmp("settings", {2'h0, v[3:2], 4'h4}, ctrlReadData[5:0]);
		end
	endtask
	task automatic t_switch;
		for (int v = 2; v < 8; v++)
		begin
			pulse(0, {4'h0, v[0], 1'h0, v[2:1]});
			tick(4);
			cmp("invSelect", {6'h00, v[2:1] == 2'h2 && v[0],
				v[2:1] != 2'h3 && v[0]}, invInputSelect);
			cmp("bufferEn", (v[2:1] == 2'h3) ? 8'h02 : 8'h00,
				inputBufferEnable[3:0]);
		end
	endtask
	task automatic t_flags;
		@(posedge clock) plusAbove <= 2'h0;
		pulse(0, 8'h00);
		pulse(0, 8'h04);
		tick(1);
		cmp("settling", 8'h00, biasSettled);
		for (int i = 0; i < 50 && biasSettled !== 1'h1; i++)
			tick(1);
		cmp("settled", 8'h01, biasSettled);
		pulse(1, 8'h00);
		pulse(2, 8'h00);
		tick(1);
		cmp("flagReady", 8'h00, irqFlag);
		@(posedge clock) {cmpIrqEnable, periphIrqEnable} <= 3'h3;
		@(posedge clock) plusAbove <= 2'h1;
		tick(4);
		cmp("flag", 8'h01, irqFlag);
		cmp("wake", 8'h01, wakeRequest);
		cmp("irq", 8'h00, irqRequest);
		pulse(2, 8'h00);
		tick(2);
		cmp("flagHeld", 8'h01, irqFlag);
		pulse(0, 8'h04);
		pulse(2, 8'h00);
		tick(2);
		cmp("flagCleared", 8'h00, irqFlag);
		@(posedge clock) globalIrqEnable <= 1'h1;
		pulse(2, 8'h01);
		tick(2);
		cmp("irq", 8'h01, irqRequest);
		@(posedge clock) clockEnable <= 1'h0;
		pulse(2, 8'h00);
		tick(1);
		cmp("frozen", 8'h01, irqFlag);
		@(posedge clock) clockEnable <= 1'h1;
		@(posedge clock) plusAbove <= 2'h0;
		@(posedge clock) plusAbove <= 2'h1;
		tick(3);
		pulse(2, 8'h00);
		tick(2);
		cmp("flagReturned", 8'h00, irqFlag);
	endtask

	// watchdog sized well above the few hundred cycles the tests need
	initial
	begin
		repeat (4000) @(posedge clock);
		n_mismatch++;
		end_sim;
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		t_reset;
		t_modes;
		t_invert;
		t_switch;
		t_flags;
		t_midreset;
		end_sim;
	end
endmodule // dual_comparator_control_tb

bind dual_comparator_control dual_comparator_control_properties
	#(.PIN_COUNT(PIN_COUNT)) props (.clock(clock), .rst(rst),
	.clockEnable(clockEnable), .ctrlWrite(ctrlWrite), .ctrlRead(ctrlRead),
	.flagWrite(flagWrite), .flagWriteData(flagWriteData),
	.cmpIrqEnable(cmpIrqEnable), .periphIrqEnable(periphIrqEnable),
	.globalIrqEnable(globalIrqEnable), .ctrlReadData(ctrlReadData),
	.ctrlValue(ctrlValue), .irqFlag(irqFlag), .irqRequest(irqRequest),
	.wakeRequest(wakeRequest), .compResult(compResult),
	.invInputSelect(invInputSelect), .portReadValue(portReadValue),
	.inputBufferEnable(inputBufferEnable));
